/* File: core/hoc_pkg.sv */
// holdover control and pll status register bank: shared constants
// assumes a byte-wide register port with word addresses as printed
package hoc_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int NUM_EVT = 7;

	// register offsets
	localparam logic [9:0] OFF_REF_MON_CFG = 10'h01A;
	localparam logic [9:0] OFF_HOLD_CTRL = 10'h01D;
	localparam logic [9:0] OFF_PLL_STATUS = 10'h01F;
	localparam logic [9:0] OFF_IRQ_STATUS = 10'h020;
	localparam logic [9:0] OFF_IRQ_MASK = 10'h021;

	// holdover control fields
	localparam int HC_HOLD_EN_LO = 0;
	localparam int HC_EXT_HOLD = 1;
	localparam int HC_HOLD_EN_HI = 2;
	localparam int HC_LD_COMP_EN = 3;
	localparam int HC_STAT_DIS = 4;
	localparam logic [7:0] HC_WR_MASK = 8'h1F;
	localparam logic [7:0] HC_RESET = 8'h00;

	// reference monitor configuration fields
	localparam int RM_THR_SEL = 6;
	localparam logic [7:0] RM_WR_MASK = 8'h40;
	localparam logic [7:0] RM_RESET = 8'h00;

	// pll status fields
	localparam int ST_LOCK = 0;
	localparam int ST_FIRST_REFERENCE_INPUT_THR = 1;
	localparam int ST_SECOND_REFERENCE_INPUT_THR = 2;
	localparam int ST_VCO_THR = 3;
	localparam int ST_SECOND_REFERENCE_INPUT_SEL = 4;
	localparam int ST_HOLD_ACT = 5;
	localparam int ST_CAL_DONE = 6;

	// interrupt registers
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] RD_IDLE = 8'h00;

	// holdover controller states, one-hot
	typedef enum logic [2:0]
	{
		HOC_IDLE = 3'b001,
		HOC_ARMED = 3'b010,
		HOC_HOLD = 3'b100
	} hoc_hold_state_t;
endpackage

/* File: core/hoc_hold_fsm.sv */
// holdover controller: automatic or pin-controlled holdover state
// assumes all inputs synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module hoc_hold_fsm
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic holdEnable,
	input wire logic extHoldMode,
	input wire logic ldCompEnable,
	input wire logic lockDetectPin,
	input wire logic holdControlPin,
	input wire logic digitalLock,
	input wire logic refLost,
	output logic holdActive
);
	hoc_pkg::hoc_hold_state_t state_reg;
	hoc_pkg::hoc_hold_state_t state_next;
	logic ldGood;

	always_comb
	begin
		ldGood = ldCompEnable ? lockDetectPin : 1'b1;
		state_next = state_reg;
		if (!holdEnable)
			state_next = hoc_pkg::HOC_IDLE;
		else if (extHoldMode)
			state_next = holdControlPin ? hoc_pkg::HOC_HOLD : hoc_pkg::HOC_IDLE;
		else
		begin
			case (state_reg)
				hoc_pkg::HOC_IDLE:
					if (digitalLock && ldGood)
						state_next = hoc_pkg::HOC_ARMED;
				hoc_pkg::HOC_ARMED:
					if (refLost)
						state_next = hoc_pkg::HOC_HOLD;
					else if (!ldGood)
						state_next = hoc_pkg::HOC_IDLE;
				hoc_pkg::HOC_HOLD:
					if (!refLost)
						state_next = hoc_pkg::HOC_IDLE;
				default:
					state_next = hoc_pkg::HOC_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= hoc_pkg::HOC_IDLE;
		else if (clkEn)
			state_reg <= state_next;
	end

	assign holdActive = (state_reg == hoc_pkg::HOC_HOLD);
endmodule
`default_nettype wire

/* File: core/hoc_event_detect.sv */
// rising-edge event detector over the status bits
// assumes status bits synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module hoc_event_detect
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [hoc_pkg::NUM_EVT-1:0] statusIn,
	output logic [hoc_pkg::NUM_EVT-1:0] eventOut
);
	logic [hoc_pkg::NUM_EVT-1:0] prev_reg;
	logic [hoc_pkg::NUM_EVT-1:0] prev_next;

	genvar i;
	generate
		for (i = 0; i < hoc_pkg::NUM_EVT; i++)
		begin : g_edge
			assign eventOut[i] = clkEn & statusIn[i] & ~prev_reg[i];
		end
	endgenerate

	always_comb
	begin
		prev_next = statusIn;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_reg <= '0;
		else if (clkEn)
			prev_reg <= prev_next;
	end
endmodule
`default_nettype wire

/* File: core/hoc_regs.sv */
// holdover control and pll status register bank with interrupt
// assumes a synchronous byte register port, inputs synchronous to sys_clk
//
// Overview of operation
// - comparator off: lock-detect pin counts high
// - comparator on: pin decides earlier lock
// - holdover needs both enable bits set
// - external bit hands holdover to pin
// - status bit 6 shows calibration finished
// - status bit 5 shows holdover active
// - status bit 4 shows second reference, low while diffRefMode is high
// - status bit 3 shows vco above threshold
// - status bit 2 shows second reference threshold
// - status bit 1 shows first reference threshold
// - status bit 0 low when unlocked
// - disable bit blocks status readback
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module hoc_regs
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [hoc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [hoc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [hoc_pkg::DATA_W-1:0] regRdData,
	input wire logic lockDetectPin,
	input wire logic holdControlPin,
	input wire logic vcoCalDone,
	input wire logic vcoAboveThr,
	input wire logic firstRefAboveThr,
	input wire logic secondRefAboveThr,
	input wire logic secondRefSelected,
	input wire logic diffRefMode,
	input wire logic digitalLock,
	input wire logic refLost,
	output logic holdoverActive,
	output logic holdoverEnabled,
	output logic externalHoldMode,
	output logic lockDetectCompEnable,
	output logic refThrSelect,
	output logic irq
);
	// address decode shared by read and write paths
	function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
		hit = (a == off);
	endfunction

	// control registers
	logic [7:0] holdCtrl_reg;
	logic [7:0] holdCtrl_next;
	logic [7:0] refMonCfg_reg;
	logic [7:0] refMonCfg_next;
	logic [7:0] irqMask_reg;
	logic [7:0] irqMask_next;

	// status and interrupt state
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] irqStatus_reg;
	logic [7:0] irqStatus_next;

	// read port
	logic [7:0] rdData_reg;
	logic [7:0] rdData_next;

	// output flops
	logic holdActOut_reg;
	logic holdActOut_next;
	logic holdEnOut_reg;
	logic holdEnOut_next;
	logic extOut_reg;
	logic extOut_next;
	logic ldCompOut_reg;
	logic ldCompOut_next;
	logic thrSelOut_reg;
	logic thrSelOut_next;
	logic irq_reg;
	logic irq_next;

	// internal nets
	logic holdEnable;
	logic holdActive;
	logic wrCtrl;
	logic wrRefMon;
	logic wrMask;
	logic rdIrqStat;
	logic [hoc_pkg::NUM_EVT-1:0] events;

	always_comb
	begin
		wrCtrl = regWrStb && hit(regAddr, hoc_pkg::OFF_HOLD_CTRL);
		wrRefMon = regWrStb && hit(regAddr, hoc_pkg::OFF_REF_MON_CFG);
		wrMask = regWrStb && hit(regAddr, hoc_pkg::OFF_IRQ_MASK);
		rdIrqStat = regRdStb && hit(regAddr, hoc_pkg::OFF_IRQ_STATUS);
		holdEnable = holdCtrl_reg[hoc_pkg::HC_HOLD_EN_HI]
			&& holdCtrl_reg[hoc_pkg::HC_HOLD_EN_LO];
	end

	// holdover controller
	hoc_hold_fsm u_hold
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.holdEnable(holdEnable),
		.extHoldMode(holdCtrl_reg[hoc_pkg::HC_EXT_HOLD]),
		.ldCompEnable(holdCtrl_reg[hoc_pkg::HC_LD_COMP_EN]),
		.lockDetectPin(lockDetectPin),
		.holdControlPin(holdControlPin),
		.digitalLock(digitalLock),
		.refLost(refLost),
		.holdActive(holdActive)
	);

	// control register group
	always_comb
	begin
		holdCtrl_next = holdCtrl_reg;
		refMonCfg_next = refMonCfg_reg;
		irqMask_next = irqMask_reg;
		if (wrCtrl)
			holdCtrl_next = regWrData & hoc_pkg::HC_WR_MASK;
		if (wrRefMon)
			refMonCfg_next = regWrData & hoc_pkg::RM_WR_MASK;
		if (wrMask)
			irqMask_next = regWrData;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			holdCtrl_reg <= hoc_pkg::HC_RESET;
			refMonCfg_reg <= hoc_pkg::RM_RESET;
			irqMask_reg <= hoc_pkg::IRQ_MASK_RESET;
		end
		else if (clkEn)
		begin
			holdCtrl_reg <= holdCtrl_next;
			refMonCfg_reg <= refMonCfg_next;
			irqMask_reg <= irqMask_next;
		end
	end

	// status sampling; no write path reaches it
	always_comb
	begin
		status_next = 8'h00;
		status_next[hoc_pkg::ST_CAL_DONE] = vcoCalDone;
		status_next[hoc_pkg::ST_HOLD_ACT] = holdActive;
		status_next[hoc_pkg::ST_SECOND_REFERENCE_INPUT_SEL] = secondRefSelected && !diffRefMode;
		status_next[hoc_pkg::ST_VCO_THR] = vcoAboveThr;
		status_next[hoc_pkg::ST_SECOND_REFERENCE_INPUT_THR] = secondRefAboveThr;
		status_next[hoc_pkg::ST_FIRST_REFERENCE_INPUT_THR] = firstRefAboveThr;
		status_next[hoc_pkg::ST_LOCK] = digitalLock;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			status_reg <= 8'h00;
		else if (clkEn)
			status_reg <= status_next;
	end

	// events from status edges
	hoc_event_detect u_evt
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.statusIn(status_reg[hoc_pkg::NUM_EVT-1:0]),
		.eventOut(events)
	);

	// sticky interrupt status, cleared by read, set wins
	always_comb
	begin
		irqStatus_next = irqStatus_reg;
		if (rdIrqStat)
			irqStatus_next = 8'h00;
		irqStatus_next[hoc_pkg::NUM_EVT-1:0] =
			irqStatus_next[hoc_pkg::NUM_EVT-1:0] | events;
		irq_next = |(irqStatus_next & irqMask_next);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqStatus_reg <= hoc_pkg::IRQ_STATUS_RESET;
			irq_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			irqStatus_reg <= irqStatus_next;
			irq_reg <= irq_next;
		end
	end

	// read port: data stands only in the cycle after the strobe
	always_comb
	begin
		rdData_next = hoc_pkg::RD_IDLE;
		if (regRdStb)
		begin
			case (regAddr)
				hoc_pkg::OFF_HOLD_CTRL:
					rdData_next = holdCtrl_reg;
				hoc_pkg::OFF_REF_MON_CFG:
					rdData_next = refMonCfg_reg;
				hoc_pkg::OFF_PLL_STATUS:
					if (!holdCtrl_reg[hoc_pkg::HC_STAT_DIS])
						rdData_next = status_reg;
				hoc_pkg::OFF_IRQ_STATUS:
					rdData_next = irqStatus_reg;
				hoc_pkg::OFF_IRQ_MASK:
					rdData_next = irqMask_reg;
				default:
					rdData_next = hoc_pkg::RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData_reg <= hoc_pkg::RD_IDLE;
		else if (clkEn)
			rdData_reg <= rdData_next;
	end

	// registered copies of the control state for the pins
	always_comb
	begin
		holdActOut_next = holdActive;
		holdEnOut_next = holdEnable;
		extOut_next = holdCtrl_reg[hoc_pkg::HC_EXT_HOLD];
		ldCompOut_next = holdCtrl_reg[hoc_pkg::HC_LD_COMP_EN];
		thrSelOut_next = refMonCfg_reg[hoc_pkg::RM_THR_SEL];
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			holdActOut_reg <= 1'b0;
			holdEnOut_reg <= 1'b0;
			extOut_reg <= 1'b0;
			ldCompOut_reg <= 1'b0;
			thrSelOut_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			holdActOut_reg <= holdActOut_next;
			holdEnOut_reg <= holdEnOut_next;
			extOut_reg <= extOut_next;
			ldCompOut_reg <= ldCompOut_next;
			thrSelOut_reg <= thrSelOut_next;
		end
	end

	assign regRdData = rdData_reg;
	assign holdoverActive = holdActOut_reg;
	assign holdoverEnabled = holdEnOut_reg;
	assign externalHoldMode = extOut_reg;
	assign lockDetectCompEnable = ldCompOut_reg;
	assign refThrSelect = thrSelOut_reg;
	assign irq = irq_reg;
endmodule
`default_nettype wire

/* File: dv/hoc_regs_monitor.sv */
// checker for hoc_regs: control copies, holdover and status readback
// assumes a bind to hoc_regs
`timescale 1ns/1ps
`default_nettype none
module hoc_regs_monitor
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [9:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic lockDetectPin,
	input wire logic holdControlPin,
	input wire logic vcoCalDone,
	input wire logic vcoAboveThr,
	input wire logic firstRefAboveThr,
	input wire logic secondRefAboveThr,
	input wire logic secondRefSelected,
	input wire logic diffRefMode,
	input wire logic digitalLock,
	input wire logic refLost,
	input wire logic holdoverActive,
	input wire logic holdoverEnabled,
	input wire logic externalHoldMode,
	input wire logic lockDetectCompEnable,
	input wire logic irq
);
	logic [7:0] wCtrl;
	logic [7:0] qCtrl;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wCtrl <= 8'h00;
			qCtrl <= 8'h00;
		end
		else if (clkEn)
		begin
			if (regWrStb && regAddr == 10'h01D)
				wCtrl <= regWrData;
			qCtrl <= wCtrl;
		end
	end
	sequence s_rs;
		clkEn && $past(clkEn) && $past(rst_n) && regRdStb && regAddr == 10'h01F && !wCtrl[4];
	endsequence
	property p_en; holdoverEnabled == (qCtrl[0] && qCtrl[2]); endproperty
	a_en: assert property (p_en) else $error("holdover enable wrong");
	property p_ext; externalHoldMode == qCtrl[1]; endproperty
	a_ext: assert property (p_ext) else $error("external mode wrong");
	property p_cmp; lockDetectCompEnable == qCtrl[3]; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator enable wrong");
	property p_xh;
		(holdoverEnabled && externalHoldMode && holdControlPin && clkEn)[*3] |-> holdoverActive;
	endproperty
	a_xh: assert property (p_xh) else $error("pin hold ignored");
	property p_off; (!holdoverEnabled && clkEn)[*3] |-> !holdoverActive; endproperty
	a_off: assert property (p_off) else $error("hold while disabled");
	property p_ld0;
		(holdoverEnabled && !externalHoldMode && !lockDetectCompEnable && digitalLock && refLost
			&& clkEn)[*4] |-> holdoverActive;
	endproperty
	a_ld0: assert property (p_ld0) else $error("pin not treated high");
	property p_ld1;
		(holdoverEnabled && !externalHoldMode && lockDetectCompEnable && !lockDetectPin && clkEn
			&& !refLost)[*3] ##1 (holdoverEnabled && !externalHoldMode && lockDetectCompEnable
			&& !lockDetectPin && clkEn)[*3] |-> !holdoverActive;
	endproperty
	a_ld1: assert property (p_ld1) else $error("low pin ignored");
	property p_sv;
		s_rs |=> regRdData[3:0] == {$past(vcoAboveThr, 2), $past(secondRefAboveThr, 2),
			$past(firstRefAboveThr, 2), $past(digitalLock, 2)};
	endproperty
	a_sv: assert property (p_sv) else $error("status low bits wrong");
	property p_sr;
		s_rs |=> regRdData[6] == $past(vcoCalDone, 2)
			&& regRdData[4] == ($past(secondRefSelected, 2) && !$past(diffRefMode, 2));
	endproperty
	a_sr: assert property (p_sr) else $error("status high bits wrong");
	property p_sd;
		clkEn && regRdStb && regAddr == 10'h01F && wCtrl[4] |=> regRdData == 8'h00;
	endproperty
	a_sd: assert property (p_sd) else $error("status read not blocked");
	c_hold: cover property ($rose(holdoverActive));
	c_irq: cover property ($rose(irq));
	c_rs: cover property (s_rs);
endmodule
bind hoc_regs hoc_regs_monitor chk_u (.*);
`default_nettype wire

/* File: dv/hoc_regs_tb_top.sv */
// testbench for hoc_regs: registers, status, holdover, interrupt
// assumes hoc_pkg, hoc_regs and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module hoc_regs_tb_top;
	logic sys_clk = 0, rst_n = 0, regWrStb = 0, regRdStb = 0, rdPend = 0, clkEn = 1;
	logic lockDetectPin = 0, holdControlPin = 0, refLost = 0;
	logic [6:0] stIn = 0;
	logic [9:0] regAddr = 0;
	logic [7:0] regWrData = 0, regRdData, d;
	logic holdoverActive, holdoverEnabled, irq, refThrSelect;
	logic [7:0] expQ[$];
	int error_cnt = 0, n_compared = 0;
	hoc_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .lockDetectPin(lockDetectPin), .holdControlPin(holdControlPin),
		.vcoCalDone(stIn[6]), .vcoAboveThr(stIn[5]), .firstRefAboveThr(stIn[1]),
		.secondRefAboveThr(stIn[2]), .secondRefSelected(stIn[4]), .diffRefMode(stIn[3]),
		.digitalLock(stIn[0]), .refLost(refLost), .holdoverActive(holdoverActive),
		.holdoverEnabled(holdoverEnabled), .externalHoldMode(), .lockDetectCompEnable(),
		.refThrSelect(refThrSelect), .irq(irq));
	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkFlag(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		expQ.push_back(e);
		@(posedge sys_clk);
		regRdStb <= 1'b0;
	endtask
	function automatic logic [7:0] expStatus(input logic h);
		return {1'b0, stIn[6], h, stIn[4] & ~stIn[3], stIn[5], stIn[2:0]};
	endfunction
	// read data checked in the cycle after each read strobe
	always @(posedge sys_clk)
	begin
		if (rdPend)
			chk("regRdData", expQ.pop_front(), regRdData);
		rdPend <= regRdStb;
	end
	initial
	begin
		#400us;
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'hE857));
		cyc(16);
		rst_n <= 1'b1;
		rd(10'h01D, 8'h00);
		rd(10'h021, 8'h00);
		rd(10'h3FF, 8'h00);
		wr(10'h021, 8'h41);
		stIn <= 7'h41;
		cyc(4);
		chkFlag("irq", 1'b1, irq);
		rd(10'h020, 8'h41);
		cyc(2);
		chkFlag("irq", 1'b0, irq);
		wr(10'h021, 8'h01);
		stIn <= 7'h61;
		cyc(4);
		chkFlag("irq", 1'b0, irq);
		rd(10'h020, 8'h08);
		d = 8'($urandom());
		wr(10'h01D, d);
		rd(10'h01D, d & 8'h1F);
		d = 8'($urandom());
		wr(10'h01A, d);
		rd(10'h01A, d & 8'h40);
		chkFlag("refThrSelect", d[6], refThrSelect);
		wr(10'h01D, 8'h00);
		repeat (8)
		begin
			stIn <= 7'($urandom());
			cyc(3);
			rd(10'h01F, expStatus(1'b0));
			wr(10'h01F, 8'hFF);
			rd(10'h01F, expStatus(1'b0));
		end
		wr(10'h01D, 8'h10);
		rd(10'h01F, 8'h00);
		stIn <= 7'h41;
		wr(10'h01D, 8'h05);
		refLost <= 1'b1;
		cyc(6);
		chkFlag("holdoverActive", 1'b1, holdoverActive);
		rd(10'h01F, expStatus(1'b1));
		refLost <= 1'b0;
		wr(10'h01D, 8'h0D);
		cyc(3);
		refLost <= 1'b1;
		cyc(6);
		chkFlag("holdoverActive", 1'b0, holdoverActive);
		lockDetectPin <= 1'b1;
		cyc(6);
		chkFlag("holdoverActive", 1'b1, holdoverActive);
		wr(10'h01D, 8'h04);
		cyc(4);
		chkFlag("holdoverEnabled", 1'b0, holdoverEnabled);
		chkFlag("holdoverActive", 1'b0, holdoverActive);
		refLost <= 1'b0;
		holdControlPin <= 1'b1;
		wr(10'h01D, 8'h07);
		cyc(4);
		chkFlag("holdoverActive", 1'b1, holdoverActive);
		holdControlPin <= 1'b0;
		cyc(4);
		chkFlag("holdoverActive", 1'b0, holdoverActive);
		clkEn <= 1'b0;
		wr(10'h01D, 8'h10);
		clkEn <= 1'b1;
		rd(10'h01D, 8'h07);
		cyc(4);
		tally_and_finish();
	end
endmodule
`default_nettype wire
